// ===== hw/cpu_soft_and_selftest_reset.sv
// Processor soft reset and self-test hard reset sequencer with its control register.
// Assumes config strobes and the reset come from the host clock domain.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Soft reset drives init low exactly 4 clocks, processor reset stays high.
// - Self-test hard reset holds processor reset low for 1 ms.
// - Init falls with processor reset and rises 4 clocks after it.
// - Trigger write launches action chosen by the two enables; both set does nothing.
// - Bit 1 enables soft reset on a trigger write.
// - Bit 3 enables self-test hard reset on the next trigger write.
// - Control register at 93h, resets to 00h, bits 7:4 and 0 read zero.
// - Only soft or self-test resets are issued; no plain hard reset.
// - Entering self-test mode sets in-order queue depth to one.
module cpu_soft_and_selftest_reset #(
  parameter int unsigned RESET_HOLD_CYCLES = reset_seq_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire reset_seq_pkg::cfg_req_t cfg_req,
  output logic [7:0]                   cfg_rdata,
  output logic                         cfg_rdata_valid,
  output logic                         processor_reset_n,
  output logic                         processor_init_n,
  output logic                         in_order_queue_depth_one
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    reset_seq_pkg::seq_state_t fsm;
    logic                      soft_reset_enable;
    logic                      self_test_enable;
    logic                      reset_out_n;
    logic                      init_out_n;
    logic                      queue_one;
    logic [7:0]                rdata;
    logic                      rvalid;
  } state_t;

  state_t                state;
  state_t                next_state;
  logic                  timer_start;
  reset_seq_pkg::tick_t  timer_length;
  logic                  timer_last;
  logic                  reg_hit;
  logic                  trigger_write;

  cycle_timer u_timer (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .start     (timer_start),
    .length    (timer_length),
    .last_tick (timer_last)
  );

  assign reg_hit       = (cfg_req.addr == reset_seq_pkg::CPU_RESET_CONTROL_OFFSET);
  assign trigger_write = cfg_req.wr && reg_hit && cfg_req.wdata[reset_seq_pkg::RESET_TRIGGER_BIT];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Register access, launch decode and pulse sequencing
  always_comb begin
    next_state        = state;
    next_state.rvalid = 1'b0;
    timer_start       = 1'b0;
    timer_length      = reset_seq_pkg::TIMER_W'(reset_seq_pkg::INIT_PULSE_CLOCKS);

    // Only bits 3 and 1 are stored; trigger reads as busy
    if (cfg_req.wr && reg_hit) begin
      next_state.soft_reset_enable = cfg_req.wdata[reset_seq_pkg::SOFT_RESET_ENABLE_BIT];
      next_state.self_test_enable  = cfg_req.wdata[reset_seq_pkg::SELF_TEST_ENABLE_BIT];
    end
    if (cfg_req.rd) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = 8'h00;  // Unmapped offsets read as zero
      if (reg_hit) begin
        next_state.rdata[reset_seq_pkg::SOFT_RESET_ENABLE_BIT] = state.soft_reset_enable;
        next_state.rdata[reset_seq_pkg::RESET_TRIGGER_BIT]     = (state.fsm != reset_seq_pkg::SEQ_IDLE);
        next_state.rdata[reset_seq_pkg::SELF_TEST_ENABLE_BIT]  = state.self_test_enable;
      end
    end

    unique case (state.fsm)
      reset_seq_pkg::SEQ_IDLE: begin
        // Enables are taken from the value stored before this write
        if (trigger_write && state.soft_reset_enable && !state.self_test_enable) begin
          next_state.fsm        = reset_seq_pkg::SEQ_SOFT;
          next_state.init_out_n = 1'b0;
          timer_start           = 1'b1;
        end else if (trigger_write && state.self_test_enable && !state.soft_reset_enable) begin
          // Self-test hard reset launch, init falls with reset
          next_state.fsm         = reset_seq_pkg::SEQ_HOLD;
          next_state.reset_out_n = 1'b0;
          next_state.init_out_n  = 1'b0;
          // Self-test mode forces queue depth one
          next_state.queue_one   = 1'b1;
          timer_start            = 1'b1;
          timer_length           = reset_seq_pkg::TIMER_W'(RESET_HOLD_CYCLES);
        end
        // Neither or both enables: no reset of any kind
      end
      reset_seq_pkg::SEQ_SOFT: begin
        if (timer_last) begin
          next_state.fsm        = reset_seq_pkg::SEQ_IDLE;
          next_state.init_out_n = 1'b1;
        end
      end
      reset_seq_pkg::SEQ_HOLD: begin
        // Reset released after the full hold time
        if (timer_last) begin
          next_state.fsm         = reset_seq_pkg::SEQ_TAIL;
          next_state.reset_out_n = 1'b1;
          timer_start            = 1'b1;
        end
      end
      reset_seq_pkg::SEQ_TAIL: begin
        // Init trails reset by four clocks
        if (timer_last) begin
          next_state.fsm        = reset_seq_pkg::SEQ_IDLE;
          next_state.init_out_n = 1'b1;
        end
      end
      default: begin
        // Illegal code: return safely with both lines released
        next_state.fsm         = reset_seq_pkg::SEQ_IDLE;
        next_state.reset_out_n = 1'b1;
        next_state.init_out_n  = 1'b1;
      end
    endcase
    // Trigger writes outside idle fall through the case untouched
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Queue-depth flag is only cleared by system reset, like the mode it reports
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.fsm               <= reset_seq_pkg::SEQ_IDLE;
      state.soft_reset_enable <= reset_seq_pkg::CPU_RESET_CONTROL_RESET[reset_seq_pkg::SOFT_RESET_ENABLE_BIT];
      state.self_test_enable  <= reset_seq_pkg::CPU_RESET_CONTROL_RESET[reset_seq_pkg::SELF_TEST_ENABLE_BIT];
      state.reset_out_n       <= 1'b1;
      state.init_out_n        <= 1'b1;
      state.queue_one         <= 1'b0;
      state.rdata             <= 8'h00;
      state.rvalid            <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign cfg_rdata                = state.rdata;
  assign cfg_rdata_valid          = state.rvalid;
  assign processor_reset_n        = state.reset_out_n;
  assign processor_init_n         = state.init_out_n;
  assign in_order_queue_depth_one = state.queue_one;

  // ****************************************************************
  // Checks
  // ****************************************************************
  localparam int HOLD_CHECK = RESET_HOLD_CYCLES;
  int low_count;

  // Counts cycles with processor reset low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_count <= 0;
    end else begin
      low_count <= processor_reset_n ? 0 : low_count + 1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence soft_launch;
    state.fsm == reset_seq_pkg::SEQ_IDLE && trigger_write && state.soft_reset_enable && !state.self_test_enable;
  endsequence
  sequence bist_launch;
    state.fsm == reset_seq_pkg::SEQ_IDLE && trigger_write && state.self_test_enable && !state.soft_reset_enable;
  endsequence
  sequence init_four_then_release;
    !processor_init_n [*4] ##1 processor_init_n;
  endsequence

  a_soft_init_len: assert property ($fell(processor_init_n) && processor_reset_n |->
    (processor_reset_n && !processor_init_n) [*4] ##1 processor_init_n)
    else $error("soft init pulse not four clocks");
  a_hold_reset_len: assert property ($rose(processor_reset_n) |-> low_count == HOLD_CHECK)
    else $error("processor reset hold length wrong");
  a_init_trails_reset: assert property ($rose(processor_reset_n) |-> init_four_then_release)
    else $error("init did not trail reset by four clocks");
  a_init_with_reset: assert property ($fell(processor_reset_n) |-> $fell(processor_init_n))
    else $error("init not asserted with reset");
  a_soft_launch: assert property (soft_launch |=> !processor_init_n && processor_reset_n)
    else $error("soft reset did not start");
  a_bist_launch: assert property (bist_launch |=> !processor_reset_n && !processor_init_n)
    else $error("self-test reset did not start");
  a_no_action: assert property (state.fsm == reset_seq_pkg::SEQ_IDLE && trigger_write &&
    (state.soft_reset_enable == state.self_test_enable) |=> processor_reset_n && processor_init_n)
    else $error("reset issued without a single enable");
  a_queue_depth: assert property ($fell(processor_reset_n) |-> in_order_queue_depth_one)
    else $error("queue depth not forced in self-test");
  // Every busy state already holds init low, so a fresh fall on either line means a relaunch
  a_busy_ignore: assert property (state.fsm != reset_seq_pkg::SEQ_IDLE && trigger_write |=>
    !$fell(processor_reset_n) && !$fell(processor_init_n))
    else $error("trigger accepted while busy");
  a_reserved_zero: assert property (cfg_rdata_valid |-> cfg_rdata[7:4] == 4'h0 && !cfg_rdata[0])
    else $error("reserved bits read nonzero");

endmodule : cpu_soft_and_selftest_reset
`default_nettype wire

// ===== hw/reset_seq_pkg.sv
// Shared constants and types for the processor reset sequencer.
// Assumes a single 125 MHz host clock and a byte-wide configuration port.
package reset_seq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CPU_RESET_CONTROL_OFFSET = 8'h93;
  localparam logic [7:0] CPU_RESET_CONTROL_RESET  = 8'h00;
  localparam int         SOFT_RESET_ENABLE_BIT    = 1;
  localparam int         RESET_TRIGGER_BIT        = 2;
  localparam int         SELF_TEST_ENABLE_BIT     = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 8;
  localparam int INIT_PULSE_CLOCKS = 4;
  localparam int RESET_HOLD_NS     = 1000000;
  // Longest hold rounds down to whole host clocks
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_NS / CLK_PERIOD_NS;
  localparam int TIMER_W           = 17;

  typedef logic [TIMER_W-1:0] tick_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_SOFT = 4'h2,
    SEQ_HOLD = 4'h4,
    SEQ_TAIL = 4'h8
  } seq_state_t;

  // Configuration access request from the bridge's config decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

endpackage : reset_seq_pkg

// ===== hw/cycle_timer.sv
// Down-counting interval timer used for the init and reset pulse lengths.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module cycle_timer (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  start,
  input  wire reset_seq_pkg::tick_t  length,
  output logic                       last_tick
);

  reset_seq_pkg::tick_t remaining;
  reset_seq_pkg::tick_t next_remaining;

  // Load on start, otherwise count down and park at zero
  always_comb begin
    if (start) begin
      next_remaining = length;
    end else if (remaining != '0) begin
      next_remaining = remaining - reset_seq_pkg::TIMER_W'(1);
    end else begin
      next_remaining = remaining;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= '0;
    end else begin
      remaining <= next_remaining;
    end
  end

  // Final cycle of the loaded interval
  assign last_tick = (remaining == reset_seq_pkg::TIMER_W'(1));

endmodule : cycle_timer
`default_nettype wire

// ===== bench/processor_model.sv
// Host processor stand-in: counts clocks spent in reset and in init.
// Assumes both inputs are registered sequencer outputs on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module processor_model (
  input  wire logic   ref_clk,
  input  wire logic   processor_reset_n,
  input  wire logic   processor_init_n,
  output logic [31:0] reset_low,
  output logic [31:0] init_low,
  output logic [31:0] init_gap
);
  // Counters only grow, so the bench diffs them and needs no clear input
  initial begin
    reset_low = 32'h0;
    init_low  = 32'h0;
    init_gap  = 32'h0;
  end
  // Init must already be low in every clock that reset is low
  always @(posedge ref_clk) begin
    if (processor_reset_n === 1'b0) reset_low <= reset_low + 32'h1;
    if (processor_init_n === 1'b0) init_low <= init_low + 32'h1;
    if (processor_reset_n === 1'b0 && processor_init_n !== 1'b0) init_gap <= init_gap + 32'h1;
  end
endmodule : processor_model
`default_nettype wire

// ===== bench/cpu_soft_and_selftest_reset_test.sv
// Self-checking bench for the processor reset sequencer.
// Assumes a shortened reset hold; inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module cpu_soft_and_selftest_reset_test;
  localparam int unsigned HOLD = 20;
  localparam logic [31:0] INIT = reset_seq_pkg::INIT_PULSE_CLOCKS;
  localparam logic [7:0]  REG  = reset_seq_pkg::CPU_RESET_CONTROL_OFFSET;
  localparam logic [7:0]  SOFT = 8'h01 << reset_seq_pkg::SOFT_RESET_ENABLE_BIT;
  localparam logic [7:0]  TRIG = 8'h01 << reset_seq_pkg::RESET_TRIGGER_BIT;
  localparam logic [7:0]  SELF = 8'h01 << reset_seq_pkg::SELF_TEST_ENABLE_BIT;
  typedef struct packed { logic [7:0] en; logic [31:0] rst; logic [31:0] ini; logic q; } row_t;
  logic                    ref_clk;
  logic                    reset_n;
  reset_seq_pkg::cfg_req_t cfg_req;
  logic [7:0]              cfg_rdata;
  logic                    cfg_rdata_valid, processor_reset_n, processor_init_n, in_order_queue_depth_one;
  logic [31:0]             reset_low, init_low, init_gap, r0, i0;
  row_t                    rows [4];
  int                      err_total, total_checks, cycles;

  cpu_soft_and_selftest_reset #(.RESET_HOLD_CYCLES(HOLD)) i_cpu_soft_and_selftest_reset (
    .ref_clk(ref_clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rdata_valid(cfg_rdata_valid), .processor_reset_n(processor_reset_n),
    .processor_init_n(processor_init_n), .in_order_queue_depth_one(in_order_queue_depth_one));
  processor_model i_processor_model (
    .ref_clk(ref_clk), .processor_reset_n(processor_reset_n), .processor_init_n(processor_init_n),
    .reset_low(reset_low), .init_low(init_low), .init_gap(init_gap));

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  // Whole run is a few hundred clocks; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    cfg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge ref_clk);
    cfg_req.wr = 1'b0;
  endtask : cfg_write
  // Valid stands one cycle, so it is looked at right after the taking edge
  task automatic cfg_read(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge ref_clk);
    cfg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge ref_clk);
    cfg_req.rd = 1'b0;
    check(cfg_rdata_valid, 1'b1);
    check(cfg_rdata, exp);
  endtask : cfg_read
  task automatic launch(input logic [7:0] en);
    r0 = reset_low;
    i0 = init_low;
    // Enables stored by a write ahead of the trigger
    // Only the reserved-code cases set both enables, to show they stay inert
    cfg_write(REG, en);
    cfg_write(REG, en | TRIG);
  endtask : launch
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cfg_req = '0;
    reset_n = 1'b0;
    rows[0] = '{en: 8'h00, rst: 32'h0, ini: 32'h0, q: 1'b0};
    rows[1] = '{en: SOFT, rst: 32'h0, ini: INIT, q: 1'b0};
    rows[2] = '{en: SELF, rst: HOLD, ini: HOLD + INIT, q: 1'b1};
    rows[3] = '{en: SOFT | SELF, rst: 32'h0, ini: 32'h0, q: 1'b1};
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    check({processor_reset_n, processor_init_n, in_order_queue_depth_one}, 3'b110);
    cfg_read(REG, reset_seq_pkg::CPU_RESET_CONTROL_RESET);
    // Trigger with both enables stored; reserved bits must not stick
    launch(8'hFF);
    repeat (10) @(negedge ref_clk);
    check(reset_low - r0, 32'h0);
    cfg_read(REG, SOFT | SELF);
    cfg_write(8'h92, 8'h00);
    cfg_read(REG, SOFT | SELF);
    cfg_read(8'h92, 8'h00);
    // Rows walk all four enable codes, each trigger one idle cycle after its enable write
    foreach (rows[k]) begin
      launch(rows[k].en);
      repeat (HOLD + 10) @(negedge ref_clk);
      check(reset_low - r0, rows[k].rst);
      check(init_low - i0, rows[k].ini);
      check(in_order_queue_depth_one, rows[k].q);
      cfg_read(REG, rows[k].en);
    end
    check(init_gap, 32'h0);
    // Retrigger while busy must leave the running sequence untouched
    launch(SELF);
    repeat (3) @(negedge ref_clk);
    cfg_read(REG, SELF | TRIG);
    cfg_write(REG, SELF | TRIG);
    repeat (HOLD + 10) @(negedge ref_clk);
    check(reset_low - r0, HOLD);
    check(init_low - i0, HOLD + INIT);
    // Reset in mid-sequence clears outputs at once
    launch(SELF);
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b0;
    #1;
    check({processor_reset_n, processor_init_n, in_order_queue_depth_one}, 3'b110);
    @(negedge ref_clk);
    reset_n = 1'b1;
    cfg_read(REG, reset_seq_pkg::CPU_RESET_CONTROL_RESET);
    complete_run();
  end
endmodule : cpu_soft_and_selftest_reset_test
`default_nettype wire
